//--- rtl/mac_frame_config_regs.sv
// Function
// - Fill disabled means no padding; CRC bit chooses append or check.
// - Pad mode 00 with fill and CRC pads short frames to 60.
// - Pad mode low bit set pads short frames to 64, high bit ignored.
// - Pad mode 10 pads untagged to 60 and VLAN tagged to 64.
// - Vendor prefix select skips first four bytes in CRC.
// - Length check compares frame length with Length/Type when it is a length.
// - Duplex select bit zero is half duplex, one is full duplex.
// - Enforce a minimum idle gap after each transmitted frame.
// - Carrier sense window is bits 14..8, not above part two.
// - Non-back-to-back gap part two is bits 6..0.
// - Collision window counts bytes from start, resets to 0x37.
// - Retransmit limit exceeded aborts the frame for excessive collisions.
// - Receive length limit is sixteen bits, reset 1536.
// - Address words 0 and 1 hold octets 6,5 and 4,3.
// - Reserved bits read zero and software writes zero.
// - Indirect access via target, data bytes and trigger register.
// - Address word 2 holds octet 2 high, octet 1 low.
`default_nettype none
module mac_frame_config_regs (
   input  wire logic                     sys_clk,
   input  wire logic                     nrst,
   input  wire mac_cfg_pkg::host_req_t   host_req,
   output logic [7:0]                    host_rdata_r,
   input  wire logic                     tx_len_req,
   input  wire logic [15:0]              tx_len,
   input  wire logic                     tx_vlan_tagged,
   output logic [15:0]                   tx_fill_count_r,
   output logic [7:0]                    tx_fill_data_r,
   input  wire mac_cfg_pkg::frame_chk_t  frame_chk,
   output logic                          tx_len_mismatch_r,
   output logic                          rx_len_mismatch_r,
   output logic                          rx_too_long_r,
   input  wire logic                     tx_frame_start,
   input  wire logic                     tx_frame_end,
   input  wire logic                     tx_back_to_back,
   input  wire logic                     tx_byte,
   input  wire logic                     tx_collision,
   output logic                          tx_gap_ok,
   output logic                          tx_cw_open_r,
   output logic                          tx_abort_r,
   output var mac_cfg_pkg::cfg_t         cfg
);
   // ****************************************************************
   // Host window and indirect registers.
   // ****************************************************************
   logic [7:0]  target_r;
   logic [7:0]  data_hi_r;
   logic [7:0]  data_lo_r;
   logic [15:0] framing_r;
   logic [15:0] b2b_gap_r;
   logic [15:0] nc_gap_r;
   logic [15:0] cw_retry_r;
   logic [15:0] rx_limit_r;
   logic [15:0] sta0_r;
   logic [15:0] sta1_r;
   logic [15:0] sta2_r;
   logic [15:0] target_val;
   logic [15:0] wdata16;
   logic        ind_wr;
   logic        ind_rd;

   assign wdata16 = {data_hi_r, data_lo_r};
   assign ind_wr  = host_req.wr && (host_req.addr == mac_cfg_pkg::HOST_TRIGGER);
   assign ind_rd  = host_req.rd && (host_req.addr == mac_cfg_pkg::HOST_TRIGGER);

   always_comb begin
      case (target_r)
         mac_cfg_pkg::REG_FRAMING:  target_val = framing_r;
         mac_cfg_pkg::REG_B2B_GAP:  target_val = b2b_gap_r;
         mac_cfg_pkg::REG_NC_GAP:   target_val = nc_gap_r;
         mac_cfg_pkg::REG_CW_RETRY: target_val = cw_retry_r;
         mac_cfg_pkg::REG_RX_LIMIT: target_val = rx_limit_r;
         mac_cfg_pkg::REG_STA0:     target_val = sta0_r;
         mac_cfg_pkg::REG_STA1:     target_val = sta1_r;
         mac_cfg_pkg::REG_STA2:     target_val = sta2_r;
         default:                   target_val = mac_cfg_pkg::RST_ZERO;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         target_r  <= 8'h00;
         data_hi_r <= 8'h00;
         data_lo_r <= 8'h00;
      end else if (ind_rd) begin
         {data_hi_r, data_lo_r} <= target_val;
      end else if (host_req.wr) begin
         case (host_req.addr)
            mac_cfg_pkg::HOST_TARGET_SEL: target_r  <= host_req.wdata;
            mac_cfg_pkg::HOST_DATA_HI:    data_hi_r <= host_req.wdata;
            mac_cfg_pkg::HOST_DATA_LO:    data_lo_r <= host_req.wdata;
            default:                      target_r  <= target_r;
         endcase
      end
   end

   // Masking on write keeps reserved bits at zero whatever software sends.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         framing_r  <= mac_cfg_pkg::RST_ZERO;
         b2b_gap_r  <= mac_cfg_pkg::RST_ZERO;
         nc_gap_r   <= mac_cfg_pkg::RST_ZERO;
         cw_retry_r <= mac_cfg_pkg::RST_CW_RETRY;
         rx_limit_r <= mac_cfg_pkg::RST_RX_LIMIT;
         sta0_r     <= mac_cfg_pkg::RST_ZERO;
         sta1_r     <= mac_cfg_pkg::RST_ZERO;
         sta2_r     <= mac_cfg_pkg::RST_ZERO;
      end else if (ind_wr) begin
         case (target_r)
            mac_cfg_pkg::REG_FRAMING:  framing_r  <= wdata16 & mac_cfg_pkg::MASK_FRAMING;
            mac_cfg_pkg::REG_B2B_GAP:  b2b_gap_r  <= wdata16 & mac_cfg_pkg::MASK_B2B_GAP;
            mac_cfg_pkg::REG_NC_GAP:   nc_gap_r   <= wdata16 & mac_cfg_pkg::MASK_NC_GAP;
            mac_cfg_pkg::REG_CW_RETRY: cw_retry_r <= wdata16 & mac_cfg_pkg::MASK_CW_RETRY;
            mac_cfg_pkg::REG_RX_LIMIT: rx_limit_r <= wdata16 & mac_cfg_pkg::MASK_FULL;
            mac_cfg_pkg::REG_STA0:     sta0_r     <= wdata16 & mac_cfg_pkg::MASK_FULL;
            mac_cfg_pkg::REG_STA1:     sta1_r     <= wdata16 & mac_cfg_pkg::MASK_FULL;
            mac_cfg_pkg::REG_STA2:     sta2_r     <= wdata16 & mac_cfg_pkg::MASK_FULL;
            default:                   sta2_r     <= sta2_r;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         host_rdata_r <= 8'h00;
      end else if (host_req.rd) begin
         case (host_req.addr)
            mac_cfg_pkg::HOST_TARGET_SEL: host_rdata_r <= target_r;
            mac_cfg_pkg::HOST_DATA_HI:    host_rdata_r <= data_hi_r;
            mac_cfg_pkg::HOST_DATA_LO:    host_rdata_r <= data_lo_r;
            default:                      host_rdata_r <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Configuration outputs.
   // ****************************************************************
   logic fill_on;
   logic pad_lo;
   logic pad_hi;

   assign fill_on = framing_r[mac_cfg_pkg::FC_FILL] && framing_r[mac_cfg_pkg::FC_CRC];
   assign pad_lo  = framing_r[mac_cfg_pkg::FC_PAD_LO];
   assign pad_hi  = framing_r[mac_cfg_pkg::FC_PAD_HI];

   assign cfg.full_duplex    = framing_r[mac_cfg_pkg::FC_FULL_DUPLEX];
   assign cfg.crc_append     = framing_r[mac_cfg_pkg::FC_CRC];
   assign cfg.crc_check      = !framing_r[mac_cfg_pkg::FC_CRC];
   assign cfg.crc_skip_bytes = framing_r[mac_cfg_pkg::FC_PREFIX] ?
                               mac_cfg_pkg::PREFIX_BYTES[2:0] : 3'h0;
   assign cfg.cs_window      = nc_gap_r[mac_cfg_pkg::CSW_MSB:mac_cfg_pkg::CSW_LSB];
   assign cfg.rx_limit       = rx_limit_r;
   assign cfg.station_addr   = {sta2_r[7:0], sta2_r[15:8], sta1_r[7:0], sta1_r[15:8],
                                sta0_r[7:0], sta0_r[15:8]};

   // ****************************************************************
   // Short frame fill.
   // ****************************************************************
   logic [15:0] pad_min;
   logic [15:0] body_len;

   always_comb begin
      if (!fill_on) begin
         pad_min = 16'h0000;
      end else if (pad_lo) begin
         pad_min = mac_cfg_pkg::PAD_LONG;
      end else if (pad_hi) begin
         pad_min = tx_vlan_tagged ? mac_cfg_pkg::PAD_LONG : mac_cfg_pkg::PAD_SHORT;
      end else begin
         pad_min = mac_cfg_pkg::PAD_SHORT;
      end
   end

   // The vendor prefix is not part of the 802.3 frame, so it does not count toward the minimum.
   assign body_len = (framing_r[mac_cfg_pkg::FC_PREFIX] && tx_len >= mac_cfg_pkg::PREFIX_BYTES) ?
                     tx_len - mac_cfg_pkg::PREFIX_BYTES : tx_len;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_fill_count_r <= 16'h0000;
         tx_fill_data_r  <= 8'h00;
      end else if (tx_len_req) begin
         tx_fill_count_r <= (body_len < pad_min) ? pad_min - body_len : 16'h0000;
         tx_fill_data_r  <= 8'h00;
      end
   end

   // ****************************************************************
   // Length checks.
   // ****************************************************************
   logic len_bad;
   assign len_bad = framing_r[mac_cfg_pkg::FC_LEN_CHECK] && frame_chk.valid &&
                    (frame_chk.type_len <= mac_cfg_pkg::MAX_LEN_FIELD) &&
                    (frame_chk.type_len != frame_chk.len);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_len_mismatch_r <= 1'b0;
         rx_len_mismatch_r <= 1'b0;
         rx_too_long_r     <= 1'b0;
      end else begin
         tx_len_mismatch_r <= len_bad && frame_chk.is_tx;
         rx_len_mismatch_r <= len_bad && !frame_chk.is_tx;
         rx_too_long_r     <= frame_chk.valid && !frame_chk.is_tx &&
                              (frame_chk.len > rx_limit_r);
      end
   end

   // ****************************************************************
   // Inter-frame gap timer.
   // ****************************************************************
   mac_cfg_pkg::gap_state_t gap_state_r;
   logic [7:0]              gap_units_r;
   logic [7:0]              div_r;
   logic [7:0]              b2b_units;

   assign b2b_units = {1'b0, b2b_gap_r[mac_cfg_pkg::GAP_MSB:mac_cfg_pkg::GAP_LSB]} +
                      (cfg.full_duplex ? mac_cfg_pkg::GAP_OFS_FULL : mac_cfg_pkg::GAP_OFS_HALF);
   assign tx_gap_ok = (gap_state_r == mac_cfg_pkg::GAP_IDLE);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gap_state_r <= mac_cfg_pkg::GAP_IDLE;
         gap_units_r <= 8'h00;
         div_r       <= 8'h00;
      end else if (tx_frame_end) begin
         gap_state_r <= mac_cfg_pkg::GAP_WAIT;
         gap_units_r <= tx_back_to_back ? b2b_units :
                        {1'b0, nc_gap_r[mac_cfg_pkg::GAP_MSB:mac_cfg_pkg::GAP_LSB]};
         div_r       <= 8'h00;
      end else begin
         case (gap_state_r)
            mac_cfg_pkg::GAP_WAIT: begin
               if (gap_units_r == 8'h00) begin
                  gap_state_r <= mac_cfg_pkg::GAP_IDLE;
               end else if (div_r == 8'(mac_cfg_pkg::GAP_UNIT_CYC - 1)) begin
                  div_r       <= 8'h00;
                  gap_units_r <= gap_units_r - 8'h01;
               end else begin
                  div_r <= div_r + 8'h01;
               end
            end
            default: gap_state_r <= mac_cfg_pkg::GAP_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Collision window and retransmit limit.
   // ****************************************************************
   logic [15:0] tx_bytes_r;
   logic [4:0]  attempts_r;
   logic [3:0]  retry_limit;

   assign retry_limit = cw_retry_r[mac_cfg_pkg::RETRY_MSB:mac_cfg_pkg::RETRY_LSB];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_bytes_r   <= 16'h0000;
         tx_cw_open_r <= 1'b0;
      end else begin
         if (tx_frame_start) begin
            tx_bytes_r <= 16'h0000;
         end else if (tx_byte && tx_bytes_r != 16'hffff) begin
            tx_bytes_r <= tx_bytes_r + 16'h0001;
         end
         tx_cw_open_r <= tx_bytes_r <
                         {10'h000, cw_retry_r[mac_cfg_pkg::CW_MSB:mac_cfg_pkg::CW_LSB]};
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         attempts_r <= 5'h00;
         tx_abort_r <= 1'b0;
      end else begin
         tx_abort_r <= 1'b0;
         if (tx_frame_start) begin
            attempts_r <= 5'h00;
         end else if (tx_collision) begin
            if (attempts_r >= {1'b0, retry_limit}) begin
               tx_abort_r <= 1'b1;
               attempts_r <= 5'h00;
            end else begin
               attempts_r <= attempts_r + 5'h01;
            end
         end
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   sequence s_ind_write;
      ind_wr ##2 ind_rd;
   endsequence
   property p_ind_readback;
      @(posedge sys_clk) disable iff (!nrst)
      s_ind_write |=> ({data_hi_r, data_lo_r} == target_val);
   endproperty
   a_ind_readback: assert property (p_ind_readback) else $error("readback mismatch");

   property p_no_fill;
      @(posedge sys_clk) disable iff (!nrst)
      (tx_len_req && !framing_r[mac_cfg_pkg::FC_FILL]) |=> (tx_fill_count_r == 16'h0000);
   endproperty
   a_no_fill: assert property (p_no_fill) else $error("fill while disabled");

   property p_pad60;
      @(posedge sys_clk) disable iff (!nrst)
      (tx_len_req && fill_on && !pad_lo && !pad_hi && !framing_r[mac_cfg_pkg::FC_PREFIX] &&
       tx_len < 16'h003c) |=> (tx_fill_count_r + $past(tx_len) == 16'h003c);
   endproperty
   a_pad60: assert property (p_pad60) else $error("short pad wrong");

   property p_pad64;
      @(posedge sys_clk) disable iff (!nrst)
      (tx_len_req && fill_on && pad_lo && !framing_r[mac_cfg_pkg::FC_PREFIX] &&
       tx_len < 16'h0040) |=> (tx_fill_count_r + $past(tx_len) == 16'h0040);
   endproperty
   a_pad64: assert property (p_pad64) else $error("long pad wrong");

   property p_vlan;
      @(posedge sys_clk) disable iff (!nrst)
      (tx_len_req && fill_on && pad_hi && !pad_lo && !framing_r[mac_cfg_pkg::FC_PREFIX] &&
       tx_len < 16'h003c) |=>
      (tx_fill_count_r + $past(tx_len) == ($past(tx_vlan_tagged) ? 16'h0040 : 16'h003c));
   endproperty
   a_vlan: assert property (p_vlan) else $error("vlan pad wrong");

   property p_prefix;
      @(posedge sys_clk) disable iff (!nrst)
      cfg.crc_skip_bytes == (framing_r[mac_cfg_pkg::FC_PREFIX] ? 3'h4 : 3'h0);
   endproperty
   a_prefix: assert property (p_prefix) else $error("prefix skip wrong");

   property p_len_check;
      @(posedge sys_clk) disable iff (!nrst)
      len_bad && frame_chk.is_tx |=> tx_len_mismatch_r && !rx_len_mismatch_r;
   endproperty
   a_len_check: assert property (p_len_check) else $error("tx mismatch lost");

   property p_gap_hold;
      @(posedge sys_clk) disable iff (!nrst)
      (tx_frame_end && !tx_back_to_back && nc_gap_r[6:0] == 7'h01)
      |=> !tx_gap_ok [*8] ##[1:60] tx_gap_ok;
   endproperty
   a_gap_hold: assert property (p_gap_hold) else $error("gap too short");

   property p_abort;
      @(posedge sys_clk) disable iff (!nrst)
      (tx_collision && !tx_frame_start && attempts_r == {1'b0, retry_limit}) |=> tx_abort_r;
   endproperty
   a_abort: assert property (p_abort) else $error("abort missing");

   property p_reserved;
      @(posedge sys_clk) disable iff (!nrst)
      ((framing_r & ~mac_cfg_pkg::MASK_FRAMING) == 16'h0000) &&
      ((cw_retry_r & ~mac_cfg_pkg::MASK_CW_RETRY) == 16'h0000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule : mac_frame_config_regs
`default_nettype wire

//--- rtl/mac_cfg_pkg.sv
`default_nettype none
package mac_cfg_pkg;
   // ****************************************************************
   // Host window and indirect target addresses.
   // ****************************************************************
   localparam logic [7:0] HOST_TARGET_SEL = 8'h0a;
   localparam logic [7:0] HOST_DATA_HI    = 8'h0b;
   localparam logic [7:0] HOST_DATA_LO    = 8'h0c;
   localparam logic [7:0] HOST_TRIGGER    = 8'h0d;
   localparam logic [7:0] REG_FRAMING     = 8'h01;
   localparam logic [7:0] REG_B2B_GAP     = 8'h02;
   localparam logic [7:0] REG_NC_GAP      = 8'h03;
   localparam logic [7:0] REG_CW_RETRY    = 8'h04;
   localparam logic [7:0] REG_RX_LIMIT    = 8'h05;
   localparam logic [7:0] REG_STA0        = 8'h10;
   localparam logic [7:0] REG_STA1        = 8'h11;
   localparam logic [7:0] REG_STA2        = 8'h12;
   // ****************************************************************
   // Writable-bit masks and reset values.
   // ****************************************************************
   localparam logic [15:0] MASK_FRAMING  = 16'h73fb;
   localparam logic [15:0] MASK_B2B_GAP  = 16'h007f;
   localparam logic [15:0] MASK_NC_GAP   = 16'h7f7f;
   localparam logic [15:0] MASK_CW_RETRY = 16'h3f0f;
   localparam logic [15:0] MASK_FULL     = 16'hffff;
   localparam logic [15:0] RST_ZERO      = 16'h0000;
   localparam logic [15:0] RST_CW_RETRY  = 16'h370f;
   localparam logic [15:0] RST_RX_LIMIT  = 16'h0600;
   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int FC_FULL_DUPLEX = 0;
   localparam int FC_LEN_CHECK   = 1;
   localparam int FC_PREFIX      = 3;
   localparam int FC_CRC         = 4;
   localparam int FC_FILL        = 5;
   localparam int FC_PAD_LO      = 6;
   localparam int FC_PAD_HI      = 7;
   localparam int GAP_LSB        = 0;
   localparam int GAP_MSB        = 6;
   localparam int CSW_LSB        = 8;
   localparam int CSW_MSB        = 14;
   localparam int CW_LSB         = 8;
   localparam int CW_MSB         = 13;
   localparam int RETRY_LSB      = 0;
   localparam int RETRY_MSB      = 3;
   // ****************************************************************
   // Frame sizes and timing.
   // ****************************************************************
   localparam logic [15:0] PAD_SHORT      = 16'h003c;
   localparam logic [15:0] PAD_LONG       = 16'h0040;
   localparam logic [15:0] PREFIX_BYTES   = 16'h0004;
   localparam logic [15:0] MAX_LEN_FIELD  = 16'h05dc;
   localparam logic [7:0]  GAP_OFS_FULL   = 8'h03;
   localparam logic [7:0]  GAP_OFS_HALF   = 8'h06;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          GAP_UNIT_NS    = 460;
   localparam int          GAP_UNIT_CYC   = (GAP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************************************************************
   // Carriers.
   // ****************************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;
   typedef struct packed {
      logic        valid;
      logic        is_tx;
      logic [15:0] len;
      logic [15:0] type_len;
   } frame_chk_t;
   typedef struct packed {
      logic        full_duplex;
      logic        crc_append;
      logic        crc_check;
      logic [2:0]  crc_skip_bytes;
      logic [6:0]  cs_window;
      logic [15:0] rx_limit;
      logic [47:0] station_addr;
   } cfg_t;
   typedef enum logic [0:0] {
      GAP_IDLE = 1'b0,
      GAP_WAIT = 1'b1
   } gap_state_t;
endpackage : mac_cfg_pkg
`default_nettype wire

//--- tb/phy_tx_model.sv
`default_nettype none
module phy_tx_model (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic start,
   input  wire logic coll,
   output var  logic tx_frame_start,
   output var  logic tx_byte,
   output var  logic tx_collision
);
   timeunit 1ns;
   timeprecision 1ns;
   logic active_r;
   // ************************************************************
   // Line activity of the transceiver.
   // ************************************************************
   // A collision is only reported once a frame has started; the line then stays active, as the model never ends a frame.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         active_r       <= 1'b0;
         tx_frame_start <= 1'b0;
         tx_byte        <= 1'b0;
         tx_collision   <= 1'b0;
      end else begin
         active_r       <= active_r | start;
         tx_frame_start <= start;
         tx_byte        <= active_r;
         tx_collision   <= coll & active_r;
      end
   end
endmodule : phy_tx_model
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    sys_clk, nrst, tx_len_req, tx_vlan_tagged, tx_frame_end;
   logic                    tx_back_to_back, start, coll, tx_frame_start, tx_byte, tx_collision;
   logic                    tx_len_mismatch_r, rx_len_mismatch_r, rx_too_long_r;
   logic                    tx_gap_ok, tx_cw_open_r, tx_abort_r;
   logic [7:0]              host_rdata_r, tx_fill_data_r;
   logic [15:0]             tx_len, tx_fill_count_r, v, r;
   logic [7:0]              ta [8];
   logic [15:0]             ma [8];
   mac_cfg_pkg::host_req_t  host_req;
   mac_cfg_pkg::frame_chk_t frame_chk;
   mac_cfg_pkg::cfg_t       cfg;
   int                      n_errors, n_compared, n, n_abort;
   mac_frame_config_regs dut (.sys_clk, .nrst, .host_req, .host_rdata_r, .tx_len_req, .tx_len,
      .tx_vlan_tagged, .tx_fill_count_r, .tx_fill_data_r, .frame_chk, .tx_len_mismatch_r,
      .rx_len_mismatch_r, .rx_too_long_r, .tx_frame_start, .tx_frame_end, .tx_back_to_back,
      .tx_byte, .tx_collision, .tx_gap_ok, .tx_cw_open_r, .tx_abort_r, .cfg);
   phy_tx_model phy (.sys_clk, .nrst, .start, .coll, .tx_frame_start, .tx_byte, .tx_collision);
   // ************************************************************
   // Helpers.
   // ************************************************************
   task automatic chk(input logic [47:0] g, input logic [47:0] x);
      n_compared++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic hx(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      host_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge sys_clk);
      host_req = '0;
   endtask : hx
   task automatic rw(input logic [7:0] t, input logic [15:0] d);
      hx(1'b1, mac_cfg_pkg::HOST_TARGET_SEL, t);
      hx(1'b1, mac_cfg_pkg::HOST_DATA_HI, d[15:8]);
      hx(1'b1, mac_cfg_pkg::HOST_DATA_LO, d[7:0]);
      hx(1'b1, mac_cfg_pkg::HOST_TRIGGER, 8'h00);
   endtask : rw
   task automatic rb(output logic [15:0] d);
      hx(1'b0, mac_cfg_pkg::HOST_TRIGGER, 8'h00);
      hx(1'b0, mac_cfg_pkg::HOST_DATA_HI, 8'h00);
      d[15:8] = host_rdata_r;
      hx(1'b0, mac_cfg_pkg::HOST_DATA_LO, 8'h00);
      d[7:0] = host_rdata_r;
   endtask : rb
   task automatic rr(input logic [7:0] t, output logic [15:0] d);
      hx(1'b1, mac_cfg_pkg::HOST_TARGET_SEL, t);
      rb(d);
   endtask : rr
   task automatic gap_run(input logic b2b, input int e);
      tx_frame_end = 1'b1;
      tx_back_to_back = b2b;
      @(negedge sys_clk);
      tx_frame_end = 1'b0;
      n = 0;
      while (tx_gap_ok !== 1'b1 && n < 2000) begin
         n++;
         @(negedge sys_clk);
      end
      chk(48'(n), 48'(e));
   endtask : gap_run
   function automatic logic [15:0] fill_exp(input logic [15:0] f, input logic [15:0] l,
                                            input logic tg);
      logic [15:0] m;
      if (f[3]) l = l - 16'h0004;
      m = (f[6] || (f[7] && tg)) ? 16'h0040 : 16'h003c;
      if (!f[5] || !f[4] || l >= m) return 16'h0000;
      return m - l;
   endfunction : fill_exp
   task automatic report_and_stop();
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (tx_abort_r === 1'b1) n_abort++;
   // The whole sequence needs about two thousand cycles; this bound only catches a hang.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      report_and_stop();
   end
   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      nrst = 1'b0; host_req = '0; tx_len_req = 1'b0; tx_len = '0; tx_vlan_tagged = 1'b0;
      frame_chk = '0; tx_frame_end = 1'b0; tx_back_to_back = 1'b0; start = 1'b0; coll = 1'b0;
      n_errors = 0; n_compared = 0; n_abort = 0;
      ta = '{mac_cfg_pkg::REG_FRAMING, mac_cfg_pkg::REG_B2B_GAP, mac_cfg_pkg::REG_NC_GAP,
             mac_cfg_pkg::REG_CW_RETRY, mac_cfg_pkg::REG_RX_LIMIT, mac_cfg_pkg::REG_STA0,
             mac_cfg_pkg::REG_STA1, 8'h07};
      ma = '{mac_cfg_pkg::MASK_FRAMING, mac_cfg_pkg::MASK_B2B_GAP, mac_cfg_pkg::MASK_NC_GAP,
             mac_cfg_pkg::MASK_CW_RETRY, 16'hffff, 16'hffff, 16'hffff, 16'h0000};
      void'($urandom(32'hbe670f17));
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      chk(cfg.rx_limit, 16'h0600);
      chk(cfg.full_duplex, 1'b0);
      rr(mac_cfg_pkg::REG_CW_RETRY, r);
      chk(r, 16'h370f);
      for (int i = 0; i < 8; i++) begin
         v = 16'($urandom()) | 16'h0011;
         rw(ta[i], v);
         rr(ta[i], r);
         chk(r, v & ma[i]);
      end
      rw(mac_cfg_pkg::REG_STA0, 16'h0605);
      rw(mac_cfg_pkg::REG_STA1, 16'h0403);
      rw(mac_cfg_pkg::REG_STA2, 16'h0201);
      chk(cfg.station_addr, 48'h010203040506);
      for (int i = 0; i < 32; i++) begin
         v = {8'h00, i[3:0], i[4], 3'b001};
         v[4] = v[4] | v[5];
         rw(mac_cfg_pkg::REG_FRAMING, v);
         chk(cfg.crc_append, v[4]);
         chk(cfg.crc_check, !v[4]);
         chk(cfg.crc_skip_bytes, v[3] ? 3'h4 : 3'h0);
         tx_len_req = 1'b1;
         tx_len = 16'd40 + 16'($urandom_range(30));
         tx_vlan_tagged = 1'($urandom_range(1));
         @(negedge sys_clk);
         tx_len_req = 1'b0;
         chk(tx_fill_count_r, fill_exp(v, tx_len, tx_vlan_tagged));
      end
      chk(tx_fill_data_r, 8'h00);
      rw(mac_cfg_pkg::REG_FRAMING, 16'h0003);
      rw(mac_cfg_pkg::REG_RX_LIMIT, 16'h05ee);
      chk(cfg.rx_limit, 16'h05ee);
      rb(r);
      chk(r, 16'h05ee);
      frame_chk = '{valid: 1'b1, is_tx: 1'b1, len: 16'h0064, type_len: 16'h005a};
      @(negedge sys_clk);
      frame_chk = '{valid: 1'b1, is_tx: 1'b0, len: 16'h05ef, type_len: 16'h0800};
      chk(tx_len_mismatch_r, 1'b1);
      @(negedge sys_clk);
      frame_chk = '{valid: 1'b1, is_tx: 1'b0, len: 16'h0032, type_len: 16'h002e};
      chk(rx_too_long_r, 1'b1);
      chk(rx_len_mismatch_r, 1'b0);
      @(negedge sys_clk);
      frame_chk.valid = 1'b0;
      chk(rx_len_mismatch_r, 1'b1);
      chk(tx_len_mismatch_r, 1'b0);
      rw(mac_cfg_pkg::REG_B2B_GAP, 16'h0000);
      gap_run(1'b1, 3 * mac_cfg_pkg::GAP_UNIT_CYC + 1);
      rw(mac_cfg_pkg::REG_NC_GAP, 16'h0101);
      chk(cfg.cs_window, 7'h01);
      gap_run(1'b0, mac_cfg_pkg::GAP_UNIT_CYC + 1);
      rw(mac_cfg_pkg::REG_FRAMING, 16'h0000);
      rw(mac_cfg_pkg::REG_B2B_GAP, 16'h0012);
      gap_run(1'b1, (18 + 6) * mac_cfg_pkg::GAP_UNIT_CYC + 1);
      rw(mac_cfg_pkg::REG_CW_RETRY, 16'h3701);
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(tx_cw_open_r, 1'b1);
      for (int k = 0; k < 2; k++) begin
         coll = 1'b1;
         @(negedge sys_clk);
         coll = 1'b0;
         repeat (4) @(negedge sys_clk);
         chk(48'(n_abort), 48'(k));
      end
      repeat (60) @(negedge sys_clk);
      chk(tx_cw_open_r, 1'b0);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
